/* File: rtl/cradc_counters.sv */
// control and counters of the cr oscillation converter
//
// Function
// - timing up/down counter, 16 bits, nibble read/write at four addresses
// - timing counter counts up on reference, down to zero on sensor
// - both counters are undefined after reset
// - oscillation up-counter, 16 bits, nibble access, counts cr clocks
// - up-counter overflow to zero switches reference oscillator to sensor
// - up-counter stops when timing counter returns to zero, then holds
// - clock select bit picks fast clock when 1, slow clock when 0
// - writing run 1 starts; reads 1 during conversion, clears at end
// - writing run 0 during conversion pauses it
// - run cleared by reset, timing counter overflow, normal completion
// - channel select picks second sensor when 1, first when 0
// - irq mask bit enables converter interrupt, cleared by reset
// - done flag set when conversion ends with timing counter at zero
// - reading the done flag returns and clears it; reset clears it
// - irq only while flag, mask and global enable are all set
// - countdown end flags on next clock fall; overflow on next rise
// - timing overflow in reference phase stops everything at once
// - flag sets even while masked, but then no interrupt
// - up-counter enabled at first cr fall, timing counter one tick later
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cradc_counters
	import cradc_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RST,
	// avalon-mm slave, word addressed
	input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input  wire logic              AVS_READ,
	input  wire logic              AVS_WRITE,
	input  wire logic [31:0]       AVS_WRITEDATA,
	output var  logic [31:0]       AVS_READDATA,
	output var  logic              AVS_WAITREQUEST,
	// clock pins and cr oscillation input
	input  wire logic              MAIN_OSC_CLK,
	input  wire logic              FAST_OSC_CLK,
	input  wire logic              CR_OSC_IN,
	// cpu interrupt side, same clock domain
	input  wire logic              GLOBAL_INTERRUPT_ENABLED,
	output var  logic              CONVERSION_IRQ,
	// oscillator drive enables
	output var  logic              REF_OSC_EN,
	output var  logic              SENSOR_ONE_EN,
	output var  logic              SENSOR_TWO_EN
);
	logic [2:0]       pins_s;
	logic             slow_s;
	logic             fast_s;
	logic             cr_s;
	logic             tick_prev_reg;
	logic             cr_prev_reg;
	logic             tick_lvl;
	logic             tick_fall;
	logic             tick_rise;
	logic             cr_fall;
	logic             clk_sel_reg;
	logic             run_reg;
	logic             chan_reg;
	logic             mask_reg;
	logic             flag_reg;
	logic             osc_armed_reg;
	logic             tim_armed_reg;
	logic             fall_pend_reg;
	logic             rise_pend_reg;
	cradc_phase_t     phase_reg;
	logic             bus_req;
	logic             bus_take;
	logic             wr_take;
	logic             rd_take;
	logic             tim_hit;
	logic             osc_hit;
	logic [SEL_W-1:0] tim_sel;
	logic [SEL_W-1:0] osc_sel;
	logic [CNT_W-1:0] tim_count;
	logic [CNT_W-1:0] osc_count;
	logic             counting;
	logic             osc_inc;
	logic             tim_inc;
	logic             tim_dec;
	logic             osc_wrap;
	logic             tim_wrap;
	logic             tim_zero_end;
	logic             conv_end;
	logic             flag_set;
	logic [31:0]      rdata_next;

	// pins come from other clocks: two flops before any logic
	cradc_sync #(
		.W(3)
	) u_sync (
		.clk  (CLK),
		.din  ({CR_OSC_IN, FAST_OSC_CLK, MAIN_OSC_CLK}),
		.dout (pins_s)
	);

	assign slow_s = pins_s[0];
	assign fast_s = pins_s[1];
	assign cr_s   = pins_s[2];

	// timing counter clock chosen by the select bit
	assign tick_lvl  = clk_sel_reg ? fast_s : slow_s;
	assign tick_fall = tick_prev_reg & ~tick_lvl;
	assign tick_rise = ~tick_prev_reg & tick_lvl;
	assign cr_fall   = cr_prev_reg & ~cr_s;

	// edge history, taken from the synchronised levels only
	always_ff @(posedge CLK) begin
		if (RST) begin
			tick_prev_reg <= 1'b0;
			cr_prev_reg   <= 1'b0;
		end else begin
			tick_prev_reg <= tick_lvl;
			cr_prev_reg   <= cr_s;
		end
	end

	// one wait state: request seen, then answered next cycle
	assign bus_req  = AVS_READ | AVS_WRITE;
	assign bus_take = bus_req & ~AVS_WAITREQUEST;
	assign wr_take  = AVS_WRITE & ~AVS_WAITREQUEST;
	assign rd_take  = AVS_READ & ~AVS_WAITREQUEST;

	always_ff @(posedge CLK) begin
		if (RST) begin
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			AVS_WAITREQUEST <= ~(bus_req & AVS_WAITREQUEST);
		end
	end

	// nibble window decode for the two counters
	assign tim_hit = (AVS_ADDRESS >= IDX_TIMING_0)
		&& (AVS_ADDRESS <= IDX_TIMING_3);
	assign osc_hit = (AVS_ADDRESS >= IDX_OSC_0)
		&& (AVS_ADDRESS <= IDX_OSC_3);
	assign tim_sel = SEL_W'(AVS_ADDRESS - IDX_TIMING_0);
	assign osc_sel = SEL_W'(AVS_ADDRESS - IDX_OSC_0);

	// counting only while running and not paused
	assign counting = run_reg && (phase_reg != CRADC_IDLE);
	assign osc_inc  = counting && osc_armed_reg && cr_fall;
	assign tim_inc  = counting && (phase_reg == CRADC_REF)
		&& tim_armed_reg && tick_fall;
	assign tim_dec  = counting && (phase_reg == CRADC_SENSOR)
		&& tim_armed_reg && tick_fall && (tim_count != CNT_ZERO);

	// wrap and end detection
	assign osc_wrap     = osc_inc && (osc_count == CNT_FULL);
	assign tim_wrap     = tim_inc && (tim_count == CNT_FULL);
	assign tim_zero_end = counting && (phase_reg == CRADC_SENSOR)
		&& tim_armed_reg && tick_fall
		&& (tim_count <= CNT_ONE);
	assign conv_end     = tim_wrap | tim_zero_end;

	// timing up/down counter, nibble access
	cradc_nibble_counter u_timing (
		.clk       (CLK),
		.load_en   (wr_take && tim_hit),
		.load_sel  (tim_sel),
		.load_data (AVS_WRITEDATA[NIB_W-1:0]),
		.inc       (tim_inc),
		.dec       (tim_dec),
		.count_reg (tim_count)
	);

	// oscillation up-counter, nibble access
	cradc_nibble_counter u_osc (
		.clk       (CLK),
		.load_en   (wr_take && osc_hit),
		.load_sel  (osc_sel),
		.load_data (AVS_WRITEDATA[NIB_W-1:0]),
		.inc       (osc_inc),
		.dec       (1'b0),
		.count_reg (osc_count)
	);

	// plain control bits written by software
	always_ff @(posedge CLK) begin
		if (RST) begin
			clk_sel_reg <= CTRL_RST;
			chan_reg    <= CTRL_RST;
			mask_reg    <= CTRL_RST;
		end else if (wr_take) begin
			if (AVS_ADDRESS == IDX_CLK_SEL) begin
				clk_sel_reg <= AVS_WRITEDATA[0];
			end else if (AVS_ADDRESS == IDX_RUN_CHAN) begin
				chan_reg <= AVS_WRITEDATA[BIT_CHAN];
			end else if (AVS_ADDRESS == IDX_IRQ_MASK) begin
				mask_reg <= AVS_WRITEDATA[0];
			end
		end
	end

	// run bit: a hardware end beats a software write in the same cycle
	always_ff @(posedge CLK) begin
		if (RST) begin
			run_reg <= CTRL_RST;
		end else if (conv_end) begin
			run_reg <= 1'b0;
		end else if (wr_take && AVS_ADDRESS == IDX_RUN_CHAN) begin
			run_reg <= AVS_WRITEDATA[BIT_RUN];
		end
	end

	// phase: idle, reference oscillation, sensor oscillation
	always_ff @(posedge CLK) begin
		if (RST) begin
			phase_reg <= CRADC_IDLE;
		end else if (conv_end) begin
			phase_reg <= CRADC_IDLE;
		end else begin
			case (phase_reg)
				CRADC_IDLE: begin
					if (wr_take && AVS_ADDRESS == IDX_RUN_CHAN
						&& AVS_WRITEDATA[BIT_RUN]) begin
						phase_reg <= CRADC_REF;
					end
				end
				CRADC_REF: begin
					if (osc_wrap) begin
						phase_reg <= CRADC_SENSOR;
					end
				end
				default: begin
					phase_reg <= phase_reg;
				end
			endcase
		end
	end

	// enable sequence: first cr fall arms the up-counter,
	// the next counter-clock fall arms the timing counter;
	// a phase switch re-arms both with the new oscillator
	always_ff @(posedge CLK) begin
		if (RST) begin
			osc_armed_reg <= 1'b0;
			tim_armed_reg <= 1'b0;
		end else if (conv_end || osc_wrap || !counting) begin
			osc_armed_reg <= 1'b0;
			tim_armed_reg <= 1'b0;
		end else begin
			if (cr_fall) begin
				osc_armed_reg <= 1'b1;
			end
			if (osc_armed_reg && tick_fall) begin
				tim_armed_reg <= 1'b1;
			end
		end
	end

	// flag timing: countdown end waits a clock fall, overflow a rise
	always_ff @(posedge CLK) begin
		if (RST) begin
			fall_pend_reg <= 1'b0;
			rise_pend_reg <= 1'b0;
		end else begin
			if (tim_zero_end) begin
				fall_pend_reg <= 1'b1;
			end else if (tick_fall) begin
				fall_pend_reg <= 1'b0;
			end
			if (tim_wrap) begin
				rise_pend_reg <= 1'b1;
			end else if (tick_rise) begin
				rise_pend_reg <= 1'b0;
			end
		end
	end

	assign flag_set = (fall_pend_reg && tick_fall)
		|| (rise_pend_reg && tick_rise);

	// done flag: set wins over the read that would clear it
	always_ff @(posedge CLK) begin
		if (RST) begin
			flag_reg <= CTRL_RST;
		end else if (flag_set) begin
			flag_reg <= 1'b1;
		end else if (rd_take && AVS_ADDRESS == IDX_DONE) begin
			flag_reg <= 1'b0;
		end
	end

	// read mux; unmapped addresses and reserved bits read zero
	always_comb begin
		rdata_next = RDATA_ZERO;
		if (tim_hit) begin
			rdata_next[NIB_W-1:0] = tim_count[tim_sel*NIB_W +: NIB_W];
		end else if (osc_hit) begin
			rdata_next[NIB_W-1:0] = osc_count[osc_sel*NIB_W +: NIB_W];
		end else if (AVS_ADDRESS == IDX_IRQ_MASK) begin
			rdata_next[0] = mask_reg;
		end else if (AVS_ADDRESS == IDX_DONE) begin
			rdata_next[BIT_FLAG] = flag_reg;
		end else if (AVS_ADDRESS == IDX_RUN_CHAN) begin
			rdata_next[BIT_RUN]  = run_reg;
			rdata_next[BIT_CHAN] = chan_reg;
		end else if (AVS_ADDRESS == IDX_CLK_SEL) begin
			rdata_next[0] = clk_sel_reg;
		end
	end

	// read data sampled while waitrequest is still high,
	// so it stands on the edge where the master takes it
	always_ff @(posedge CLK) begin
		if (RST) begin
			AVS_READDATA <= RDATA_ZERO;
		end else if (AVS_READ && AVS_WAITREQUEST) begin
			AVS_READDATA <= rdata_next;
		end
	end

	// oscillator drives: off while paused or idle
	always_ff @(posedge CLK) begin
		if (RST) begin
			REF_OSC_EN    <= 1'b0;
			SENSOR_ONE_EN <= 1'b0;
			SENSOR_TWO_EN <= 1'b0;
		end else begin
			REF_OSC_EN    <= counting && !conv_end && !osc_wrap
				&& (phase_reg == CRADC_REF);
			SENSOR_ONE_EN <= counting && !conv_end && !chan_reg
				&& ((phase_reg == CRADC_SENSOR) || osc_wrap);
			SENSOR_TWO_EN <= counting && !conv_end && chan_reg
				&& ((phase_reg == CRADC_SENSOR) || osc_wrap);
		end
	end

	// interrupt request; a read racing the flag set may miss it
	always_ff @(posedge CLK) begin
		if (RST) begin
			CONVERSION_IRQ <= 1'b0;
		end else begin
			CONVERSION_IRQ <= flag_reg && mask_reg
				&& GLOBAL_INTERRUPT_ENABLED;
		end
	end
endmodule // cradc_counters
`default_nettype wire

/* File: rtl/cradc_nibble_counter.sv */
// 16-bit counter with nibble load, increment and decrement
`timescale 1ns/1ps
`default_nettype none
module cradc_nibble_counter
	import cradc_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             load_en,
	input  wire logic [SEL_W-1:0] load_sel,
	input  wire logic [NIB_W-1:0] load_data,
	input  wire logic             inc,
	input  wire logic             dec,
	output var  logic [CNT_W-1:0] count_reg
);
	logic [CNT_W-1:0] count_next;

	// a bus write wins over counting in the same cycle
	always_comb begin
		count_next = count_reg;
		if (load_en) begin
			count_next[load_sel*NIB_W +: NIB_W] = load_data;
		end else if (inc) begin
			count_next = count_reg + CNT_ONE;
		end else if (dec) begin
			count_next = count_reg - CNT_ONE;
		end
	end

	// no reset: contents are undefined after reset
	always_ff @(posedge clk) begin
		count_reg <= count_next;
	end
endmodule // cradc_nibble_counter
`default_nettype wire

/* File: rtl/cradc_pkg.sv */
// shared constants for the cr oscillation converter counters
package cradc_pkg;
	localparam int          NIB_W        = 4;
	localparam int          CNT_W        = 16;
	localparam int          ADDR_W       = 8;
	localparam int          SEL_W        = 2;
	// register indices; byte address is four times the index
	localparam logic [7:0]  IDX_TIMING_0 = 8'hE4;
	localparam logic [7:0]  IDX_TIMING_3 = 8'hE7;
	localparam logic [7:0]  IDX_IRQ_MASK = 8'hEC;
	localparam logic [7:0]  IDX_DONE     = 8'hF0;
	localparam logic [7:0]  IDX_RUN_CHAN = 8'hF1;
	localparam logic [7:0]  IDX_OSC_0    = 8'hF5;
	localparam logic [7:0]  IDX_OSC_3    = 8'hF8;
	localparam logic [7:0]  IDX_CLK_SEL  = 8'hFE;
	// field positions
	localparam int          BIT_RUN      = 0;
	localparam int          BIT_CHAN     = 3;
	localparam int          BIT_FLAG     = 0;
	// reset values and counter landmarks
	localparam logic        CTRL_RST     = 1'b0;
	localparam logic [15:0] CNT_ZERO     = 16'h0000;
	localparam logic [15:0] CNT_ONE      = 16'h0001;
	localparam logic [15:0] CNT_FULL     = 16'hFFFF;
	localparam logic [31:0] RDATA_ZERO   = 32'h00000000;
	// conversion phases
	typedef enum logic [1:0] {
		CRADC_IDLE,
		CRADC_REF,
		CRADC_SENSOR
	} cradc_phase_t;
endpackage

/* File: rtl/cradc_sync.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module cradc_sync #(
	parameter int W = 3
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		meta_reg <= din;
		dout     <= meta_reg;
	end
endmodule // cradc_sync
`default_nettype wire

/* File: tb/cradc_chk.sv */
// assertion checker for the converter counter block
`timescale 1ns/1ps
`default_nettype none
module cradc_chk
	import cradc_pkg::*;
(
	input wire logic              CLK,
	input wire logic              RST,
	input wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input wire logic              AVS_READ,
	input wire logic              AVS_WRITE,
	input wire logic [31:0]       AVS_WRITEDATA,
	input wire logic [31:0]       AVS_READDATA,
	input wire logic              AVS_WAITREQUEST,
	input wire logic              GLOBAL_INTERRUPT_ENABLED,
	input wire logic              CONVERSION_IRQ,
	input wire logic              REF_OSC_EN,
	input wire logic              SENSOR_ONE_EN,
	input wire logic              SENSOR_TWO_EN
);
	// accepted bus beats and oscillator drive of any kind
	logic acc;
	logic en;
	logic run_wr;
	assign acc = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
	assign en = REF_OSC_EN | SENSOR_ONE_EN | SENSOR_TWO_EN;
	assign run_wr = acc & AVS_WRITE & (AVS_ADDRESS == IDX_RUN_CHAN);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	// bus answers last one cycle and only follow a request
	property p_ack_one;
		!AVS_WAITREQUEST |=> AVS_WAITREQUEST;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_ack_cause;
		$fell(AVS_WAITREQUEST) |-> $past(AVS_READ | AVS_WRITE);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
	property p_rsvd;
		acc && AVS_READ |-> AVS_READDATA[31:4] == 28'h0000000;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
	// never two elements oscillating together
	property p_one_osc;
		$onehot0({REF_OSC_EN, SENSOR_ONE_EN, SENSOR_TWO_EN});
	endproperty
	a_one_osc: assert property (p_one_osc) else $error("two osc on");
	// run writes start or stop the oscillator within a few cycles
	property p_start;
		run_wr && AVS_WRITEDATA[BIT_RUN] |-> ##[1:4] en;
	endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_pause;
		run_wr && !AVS_WRITEDATA[BIT_RUN] |-> ##3 !en;
	endproperty
	a_pause: assert property (p_pause) else $error("no pause");
	// interrupt needs global enable; flag read and masking drop it
	property p_irq_gie;
		CONVERSION_IRQ |-> $past(GLOBAL_INTERRUPT_ENABLED);
	endproperty
	a_irq_gie: assert property (p_irq_gie) else $error("irq ungated");
	property p_flag_rd;
		acc && AVS_READ && AVS_ADDRESS == IDX_DONE && AVS_READDATA[BIT_FLAG]
			|-> ##2 !CONVERSION_IRQ;
	endproperty
	a_flag_rd: assert property (p_flag_rd) else $error("irq kept");
	property p_mask;
		acc && AVS_WRITE && AVS_ADDRESS == IDX_IRQ_MASK && !AVS_WRITEDATA[0]
			|-> ##2 !CONVERSION_IRQ;
	endproperty
	a_mask: assert property (p_mask) else $error("masked irq");
	c_irq: cover property ($rose(CONVERSION_IRQ));
	c_two: cover property ($rose(SENSOR_TWO_EN));
	c_pause: cover property (run_wr && !AVS_WRITEDATA[BIT_RUN] && en);
endmodule // cradc_chk
bind cradc_counters cradc_chk cradc_chk_i (.CLK, .RST, .AVS_ADDRESS,
	.AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST,
	.GLOBAL_INTERRUPT_ENABLED, .CONVERSION_IRQ, .REF_OSC_EN, .SENSOR_ONE_EN,
	.SENSOR_TWO_EN);
`default_nettype wire

/* File: tb/cradc_osc_model.sv */
// behavioural cr oscillator: reference resistor and two sensors
`timescale 1ns/1ps
`default_nettype none
module cradc_osc_model #(
	parameter int REF_HALF = 500,
	parameter int ONE_HALF = 500,
	parameter int TWO_HALF = 300
) (
	input  wire logic ref_en,
	input  wire logic one_en,
	input  wire logic two_en,
	output var  logic cr_osc
);
	// toggles only while an element is driven, stands high otherwise
	int half;
	always begin
		half = (ref_en === 1'b1) ? REF_HALF : (one_en === 1'b1) ? ONE_HALF :
			(two_en === 1'b1) ? TWO_HALF : 0;
		if (half == 0) begin
			cr_osc = 1'b1;
			@(ref_en or one_en or two_en);
		end else begin
			#(half) cr_osc = ~cr_osc;
		end
	end
endmodule // cradc_osc_model
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the converter counter block
`timescale 1ns/1ps
`default_nettype none
module tb
	import cradc_pkg::*;
;
	logic              CLK, RST, AVS_READ, AVS_WRITE, CR_OSC_IN;
	logic              MAIN_OSC_CLK, FAST_OSC_CLK, GLOBAL_INTERRUPT_ENABLED;
	logic              AVS_WAITREQUEST, CONVERSION_IRQ, REF_OSC_EN;
	logic              SENSOR_ONE_EN, SENSOR_TWO_EN, saw1, saw2, saw_irq;
	logic [ADDR_W-1:0] AVS_ADDRESS;
	logic [31:0]       AVS_WRITEDATA, AVS_READDATA;
	logic [3:0]        q;
	logic [15:0]       v, w;
	int                mismatches, checks_done;
	logic [7:0]        ra [5] = '{IDX_CLK_SEL, IDX_RUN_CHAN, IDX_IRQ_MASK,
		IDX_DONE, 8'h10};
	logic [3:0]        wv [5] = '{4'hF, 4'hE, 4'hF, 4'hF, 4'hF};
	logic [3:0]        ev [5] = '{4'h1, 4'h8, 4'h1, 4'h0, 4'h0};

	cradc_counters cradc_counters_i (.CLK, .RST, .AVS_ADDRESS, .AVS_READ,
		.AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST,
		.MAIN_OSC_CLK, .FAST_OSC_CLK, .CR_OSC_IN, .GLOBAL_INTERRUPT_ENABLED,
		.CONVERSION_IRQ, .REF_OSC_EN, .SENSOR_ONE_EN, .SENSOR_TWO_EN);
	cradc_osc_model cradc_osc_model_i (.ref_en(REF_OSC_EN),
		.one_en(SENSOR_ONE_EN), .two_en(SENSOR_TWO_EN), .cr_osc(CR_OSC_IN));

	// system clock; fast counting clock is twice the slow one
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	initial begin
		MAIN_OSC_CLK = 1'b0;
		forever #200 MAIN_OSC_CLK = ~MAIN_OSC_CLK;
	end
	initial begin
		FAST_OSC_CLK = 1'b0;
		forever #100 FAST_OSC_CLK = ~FAST_OSC_CLK;
	end

	// remember which elements ran and whether an interrupt showed
	always @(posedge CLK) begin
		if (SENSOR_ONE_EN === 1'b1) saw1 <= 1'b1;
		if (SENSOR_TWO_EN === 1'b1) saw2 <= 1'b1;
		if (CONVERSION_IRQ === 1'b1) saw_irq <= 1'b1;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] s, e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask

	// one avalon beat, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [3:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		AVS_ADDRESS <= a;
		AVS_WRITE <= wr;
		AVS_READ <= ~wr;
		AVS_WRITEDATA <= {28'h0000000, d};
		do begin
			@(posedge CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 40);
		q = AVS_READDATA[3:0];
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		if (AVS_WAITREQUEST !== 1'b0) begin
			mismatches++;
			results();
		end
	endtask

	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		for (int i = 0; i < 4; i++)
			bus(1'b1, a + 8'(i), d[4*i+:4]);
	endtask

	task automatic rd16(input logic [7:0] a);
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, a + 8'(i), 4'h0);
			v[4*i+:4] = q;
		end
	endtask

	// bounded polls on bit 0 of a register, read over the bus
	task automatic poll(input logic [7:0] a, input logic want);
		int n;
		n = 0;
		do begin
			bus(1'b0, a, 4'h0);
			n++;
		end while (q[0] !== want && n < 2000);
		if (q[0] !== want) begin
			mismatches++;
			results();
		end
	endtask

	// sel 0 waits for the reference drive, 1 for the interrupt line
	task automatic wait_hi(input logic sel);
		int n;
		n = 0;
		while ((sel ? CONVERSION_IRQ : REF_OSC_EN) !== 1'b1
			&& n < 4000) begin
			@(posedge CLK);
			n++;
		end
		if ((sel ? CONVERSION_IRQ : REF_OSC_EN) !== 1'b1) begin
			mismatches++;
			results();
		end
	endtask

	task automatic conv(input logic [3:0] ctl, input logic [15:0] osc, tc,
		input logic [3:0] cs);
		bus(1'b1, IDX_CLK_SEL, cs);
		wr16(IDX_OSC_0, osc);
		wr16(IDX_TIMING_0, tc);
		bus(1'b1, IDX_RUN_CHAN, ctl & 4'h8);
		saw1 <= 1'b0;
		saw2 <= 1'b0;
		bus(1'b1, IDX_RUN_CHAN, ctl);
		wait_hi(1'b0);
	endtask

	initial begin
		RST = 1'b1;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_ADDRESS = 8'h00;
		AVS_WRITEDATA = 32'h00000000;
		GLOBAL_INTERRUPT_ENABLED = 1'b0;
		saw_irq = 1'b0;
		repeat (10) @(posedge CLK);
		RST <= 1'b0;
		// reset values, then access kinds, including an unmapped index
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, ra[i], 4'h0);
			chk("rst", 16'(q), 16'h0000);
			bus(1'b1, ra[i], wv[i]);
			bus(1'b0, ra[i], 4'h0);
			chk("acc", 16'(q), 16'(ev[i]));
		end
		wr16(IDX_TIMING_0, 16'h4321);
		wr16(IDX_OSC_0, 16'hDCBA);
		rd16(IDX_TIMING_0);
		chk("tc", v, 16'h4321);
		rd16(IDX_OSC_0);
		chk("osc", v, 16'hDCBA);
		// first sensor, slow clock, interrupt held off globally
		conv(4'h1, 16'hFFFC, 16'h0000, 4'h0);
		poll(IDX_RUN_CHAN, 1'b0);
		chk("sens", {14'h0000, saw2, saw1}, 16'h0001);
		chk("gated", 16'(CONVERSION_IRQ), 16'h0000);
		GLOBAL_INTERRUPT_ENABLED <= 1'b1;
		wait_hi(1'b1);
		rd16(IDX_TIMING_0);
		chk("cdown", v, 16'h0000);
		// flag read only after the request showed, so no race with its set
		bus(1'b0, IDX_DONE, 4'h0);
		chk("flag", 16'(q), 16'h0001);
		bus(1'b0, IDX_DONE, 4'h0);
		chk("clr", {15'h0000, q[0] | CONVERSION_IRQ}, 16'h0000);
		// second sensor, fast clock, masked, paused in the reference phase
		bus(1'b1, IDX_IRQ_MASK, 4'h0);
		saw_irq <= 1'b0;
		conv(4'h9, 16'hFFFC, 16'h0000, 4'h1);
		bus(1'b1, IDX_RUN_CHAN, 4'h8);
		bus(1'b0, IDX_RUN_CHAN, 4'h0);
		chk("pause", 16'(q), 16'h0008);
		rd16(IDX_OSC_0);
		w = v;
		chk("held", w, 16'hFFFC);
		repeat (200) @(posedge CLK);
		rd16(IDX_OSC_0);
		chk("hold", v, w);
		bus(1'b1, IDX_RUN_CHAN, 4'h9);
		poll(IDX_RUN_CHAN, 1'b0);
		poll(IDX_DONE, 1'b1);
		chk("sens2", {14'h0000, saw2, saw1}, 16'h0002);
		chk("masked", 16'(saw_irq), 16'h0000);
		// timing counter overflows while the reference still runs
		conv(4'h1, 16'hF000, 16'hFFF0, 4'h1);
		poll(IDX_RUN_CHAN, 1'b0);
		rd16(IDX_TIMING_0);
		chk("ovf", v, 16'h0000);
		chk("stop", {13'h0000, REF_OSC_EN, saw2, saw1}, 16'h0000);
		poll(IDX_DONE, 1'b1);
		results();
	end
endmodule // tb
`default_nettype wire
